// [shared/mrs_pkg.sv]
package mrs_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned PU_DELAY_MS   = 50;
   localparam int unsigned PU_DELAY_CYC  =
      PU_DELAY_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned SST_CYC       = 16;
   localparam int unsigned UV_MIN_NS     = 1000;
   localparam int unsigned UV_MIN_CYC    =
      (UV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BAD_SEL_EDGES = 3;

   // ****************************************
   // pin-select field
   // ****************************************
   localparam int         SEL_W       = 5;
   localparam logic [4:0] SEL_IO      = 5'h00;
   localparam logic [4:0] SEL_RESET   = 5'h15;
   localparam logic [4:0] SEL_RST_VAL = 5'h00;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [31:0] OFF_SEL     = 32'h0000_0000;
   localparam logic [31:0] OFF_FLAGS   = 32'h0000_0004;
   localparam logic [31:0] OFF_IRQ_ST  = 32'h0000_0008;
   localparam logic [31:0] OFF_IRQ_CLR = 32'h0000_000c;
   localparam logic [31:0] OFF_IRQ_EN  = 32'h0000_0010;

   localparam int FLG_TO    = 0;
   localparam int FLG_PDF   = 1;
   localparam int FLG_SLEEP = 2;

   localparam int EV_PIN  = 0;
   localparam int EV_UV   = 1;
   localparam int EV_WDT  = 2;
   localparam int EV_WAKE = 3;
   localparam int EV_SEL  = 4;
   localparam int EV_W    = 5;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_HOLD,
      ST_DELAY,
      ST_SST,
      ST_SLEEP
   } mrs_state_t;

endpackage : mrs_pkg

// [src/mrs_top.sv]
module mrs_top #(
   parameter int unsigned PU_DELAY_CYC = mrs_pkg::PU_DELAY_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        external_init_pin_n_i,
   input  wire logic        undervoltage_monitor_i,
   input  wire logic        slow_internal_osc_i,
   input  wire logic        wdt_ovf_i,
   input  wire logic        halt_i,
   input  wire logic        clrwdt_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic             core_rst_n_o,
   output logic             pc_clr_o,
   output logic             port_preset_o,
   output logic             run_o,
   output logic             init_pin_is_reset_o,
   output logic             irq_o
);
   import mrs_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [1:0] pin_sy_q;
   logic [1:0] uv_sy_q;
   logic [1:0] osc_sy_q;
   logic       osc_d1_q;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pin_sy_q <= 2'h3;
         uv_sy_q  <= 2'h0;
         osc_sy_q <= 2'h0;
         osc_d1_q <= 1'b0;
      end else begin
         pin_sy_q <= {pin_sy_q[0], external_init_pin_n_i};
         uv_sy_q  <= {uv_sy_q[0], undervoltage_monitor_i};
         osc_sy_q <= {osc_sy_q[0], slow_internal_osc_i};
         osc_d1_q <= osc_sy_q[1];
      end
   end

   wire pin_low  = ~pin_sy_q[1];
   wire uv_s     = uv_sy_q[1];
   wire osc_rise = osc_sy_q[1] & ~osc_d1_q;

   // ****************************************
   // state and trigger decode
   // ****************************************
   mrs_state_t      state_q;
   mrs_state_t      state_d;
   logic [4:0]      sel_q;
   logic [4:0]      sel_d;
   logic [1:0]      bad_cnt_q;
   logic [15:0]     uv_cnt_q;
   logic [31:0]     dly_cnt_q;
   logic [3:0]      sst_cnt_q;
   logic            to_q;
   logic            pdf_q;
   logic [EV_W-1:0] stat_q;
   logic [EV_W-1:0] stat_d;
   logic [EV_W-1:0] en_q;
   logic [EV_W-1:0] en_d;
   logic [EV_W-1:0] ev;
   logic            dp_we_q;
   logic            dp_rd_sel_q;
   logic [31:0]     dp_addr_q;
   logic [31:0]     flags_v;
   logic [31:0]     rd_mux;

   wire sel_is_rst = (sel_q == SEL_RESET);
   wire sel_bad    = (sel_q != SEL_IO) && !sel_is_rst;
   wire pin_trig   = sel_is_rst & pin_low;
   // masking in sleep keeps a sagging battery from waking the part
   wire uv_armed   = uv_s & (state_q != ST_SLEEP);
   wire uv_trig    = uv_armed &
                     (uv_cnt_q == 16'(UV_MIN_CYC - 1));
   wire bad_trig   = sel_bad & osc_rise &
                     (bad_cnt_q == 2'(BAD_SEL_EDGES - 1));
   wire wdt_run    = wdt_ovf_i & (state_q == ST_RUN);
   wire wdt_wake   = wdt_ovf_i & (state_q == ST_SLEEP);
   wire full_trig  = pin_trig | uv_trig | bad_trig | wdt_run;
   wire halt_go    = halt_i & (state_q == ST_RUN) & ~full_trig;
   wire dly_done   = (dly_cnt_q == 32'(PU_DELAY_CYC - 1));
   wire sst_done   = (sst_cnt_q == 4'(SST_CYC - 1));
   wire rel_hold   = (state_q == ST_HOLD) && (state_d == ST_DELAY);

   always_comb begin
      state_d = state_q;
      if (full_trig) begin
         state_d = ST_HOLD;
      end else begin
         unique case (state_q)
            ST_RUN:   if (halt_go) state_d = ST_SLEEP;
            ST_HOLD:  state_d = ST_DELAY;
            ST_DELAY: if (dly_done) state_d = ST_SST;
            ST_SST:   if (sst_done) state_d = ST_RUN;
            ST_SLEEP: if (wdt_wake) state_d = ST_SST;
            default:  state_d = ST_HOLD;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_q <= ST_DELAY;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // counters
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!nrst_i || state_q != ST_DELAY || full_trig) begin
         dly_cnt_q <= 32'h0;
      end else begin
         dly_cnt_q <= dly_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i || state_q != ST_SST) begin
         sst_cnt_q <= 4'h0;
      end else begin
         sst_cnt_q <= sst_cnt_q + 4'h1;
      end
   end

   // saturates, so a long dip keeps the hold asserted
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !uv_armed) begin
         uv_cnt_q <= 16'h0;
      end else if (!uv_trig) begin
         uv_cnt_q <= uv_cnt_q + 16'h1;
      end
   end

   // three edges from an arbitrary phase span two to three periods
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !sel_bad) begin
         bad_cnt_q <= 2'h0;
      end else if (osc_rise) begin
         bad_cnt_q <= bad_trig ? 2'h0 : bad_cnt_q + 2'h1;
      end
   end

   // ****************************************
   // ahb-lite slave
   // ****************************************
   wire ap       = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2);
   wire wr_sel   = dp_we_q && (dp_addr_q == OFF_SEL);
   wire wr_clr   = dp_we_q && (dp_addr_q == OFF_IRQ_CLR);
   wire wr_en    = dp_we_q && (dp_addr_q == OFF_IRQ_EN);

   always_comb begin
      flags_v            = 32'h0;
      flags_v[FLG_TO]    = to_q;
      flags_v[FLG_PDF]   = pdf_q;
      flags_v[FLG_SLEEP] = (state_q == ST_SLEEP);
   end

   assign rd_mux =
      (haddr_i == OFF_SEL)    ? {27'h0, sel_q} :
      (haddr_i == OFF_FLAGS)  ? flags_v :
      (haddr_i == OFF_IRQ_ST) ? {27'h0, stat_q} :
      (haddr_i == OFF_IRQ_EN) ? {27'h0, en_q} : 32'h0;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         dp_we_q     <= 1'b0;
         dp_rd_sel_q <= 1'b0;
         dp_addr_q   <= 32'h0;
         hrdata_o    <= 32'h0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         dp_we_q     <= ap & hwrite_i;
         dp_rd_sel_q <= ap & ~hwrite_i & (haddr_i == OFF_SEL);
         dp_addr_q   <= haddr_i;
         hrdata_o    <= (ap & ~hwrite_i) ? rd_mux : 32'h0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // ****************************************
   // pin select, flags, interrupts
   // ****************************************
   always_comb begin
      sel_d = sel_q;
      if (rel_hold) begin
         sel_d = SEL_RST_VAL;
      end else if (wr_sel) begin
         sel_d = hwdata_i[SEL_W-1:0];
      end
   end

   assign ev[EV_PIN]  = pin_trig & (state_q != ST_HOLD);
   assign ev[EV_UV]   = uv_trig & (state_q != ST_HOLD);
   assign ev[EV_WDT]  = wdt_run;
   assign ev[EV_WAKE] = wdt_wake;
   assign ev[EV_SEL]  = bad_trig;
   // a new event beats a clear written in the same cycle
   assign stat_d = (stat_q & ~(wr_clr ? hwdata_i[EV_W-1:0] : '0)) | ev;
   assign en_d   = wr_en ? hwdata_i[EV_W-1:0] : en_q;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sel_q  <= SEL_RST_VAL;
         stat_q <= '0;
         en_q   <= '0;
      end else begin
         sel_q  <= sel_d;
         stat_q <= stat_d;
         en_q   <= en_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         to_q  <= 1'b0;
         pdf_q <= 1'b0;
      end else begin
         if (wdt_run || wdt_wake) begin
            to_q <= 1'b1;
         end
         if (wdt_wake || halt_go) begin
            pdf_q <= 1'b1;
         end else if (clrwdt_i) begin
            pdf_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   wire full_rst_d = (state_d == ST_HOLD) || (state_d == ST_DELAY);

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         core_rst_n_o        <= 1'b0;
         pc_clr_o            <= 1'b1;
         port_preset_o       <= 1'b1;
         run_o               <= 1'b0;
         init_pin_is_reset_o <= 1'b0;
         irq_o               <= 1'b0;
      end else begin
         core_rst_n_o        <= ~full_rst_d;
         pc_clr_o            <= full_rst_d ||
                                (state_d == ST_SST);
         port_preset_o       <= full_rst_d;
         run_o               <= (state_d == ST_RUN);
         init_pin_is_reset_o <= (sel_d == SEL_RESET);
         irq_o               <= |(stat_d & en_d);
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   // consecutive high cycles of the synchronised monitor, kept apart from
   // the qualifying counter so that the check does not restate it
   logic [15:0] uv_hi_q;

   always_ff @(posedge clk_i) begin
      if (!nrst_i || !uv_s) begin
         uv_hi_q <= 16'h0;
      end else if (uv_hi_q != 16'hffff) begin
         uv_hi_q <= uv_hi_q + 16'h1;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_warm;
      ##1 (!run_o && core_rst_n_o && pc_clr_o)[*8];
   endsequence

   sequence s_full;
      ##1 (!core_rst_n_o && port_preset_o && state_q == ST_HOLD);
   endsequence

   AST_PC_BEFORE_RUN: assert property (
      $rose(run_o) |-> $past(pc_clr_o))
      else $error("run started without pc clear");

   AST_PORT_PRESET: assert property (
      !core_rst_n_o |-> (port_preset_o && pc_clr_o && !run_o))
      else $error("full reset without port preset");

   AST_PIN_RESET: assert property (
      (state_q == ST_RUN && pin_trig) |-> s_full)
      else $error("init pin did not reset");

   AST_DELAY_HOLDS: assert property (
      (state_q == ST_DELAY && !dly_done && !full_trig)
      |=> (state_q == ST_DELAY && !run_o))
      else $error("power-up delay cut short");

   AST_BAD_SEL: assert property (
      (sel_bad && osc_rise && bad_cnt_q == 2'(BAD_SEL_EDGES - 1))
      |-> s_full)
      else $error("illegal pin select did not reset");

   AST_SEL_UPPER_ZERO: assert property (
      dp_rd_sel_q |-> (hrdata_o[31:5] == 27'h0))
      else $error("pin select upper bits not zero");

   AST_UV_QUALIFIED: assert property (
      uv_trig |-> (uv_hi_q >= 16'(UV_MIN_CYC - 1)))
      else $error("undervoltage acted before qualification");

   AST_UV_SLEEP_MASK: assert property (
      (state_q == ST_SLEEP && !pin_trig && !bad_trig)
      |=> core_rst_n_o)
      else $error("reset taken in sleep by masked source");

   AST_WDT_RUN: assert property (
      wdt_run |-> s_full ##0 to_q)
      else $error("run watchdog reset wrong");

   AST_WDT_WAKE: assert property (
      (wdt_wake && !full_trig) |-> s_warm ##9 run_o)
      else $error("start-up timer length wrong");

   AST_WAKE_FLAGS: assert property (
      wdt_wake |=> (to_q && pdf_q && core_rst_n_o))
      else $error("wake flags wrong");

   AST_HALT_PDF: assert property (
      halt_go |=> (pdf_q && state_q == ST_SLEEP && !run_o))
      else $error("halt did not set power-down flag");

   AST_CLRWDT_PDF: assert property (
      (clrwdt_i && !halt_go && !wdt_wake) |=> !pdf_q)
      else $error("clear-watchdog did not clear flag");

endmodule : mrs_top

// [testbench/mrs_pin_model.sv]
module mrs_pin_model (
   input  wire logic       clk_i,
   input  wire logic       press_i,
   input  wire logic [7:0] hold_i,
   output logic            pin_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // switch on the init pin
   // ****************************************
   logic [7:0] cnt_q = 8'h00;

   // pull-up returns the line high once the switch opens
   assign pin_n_o = (cnt_q == 8'h00);

   always @(posedge clk_i) begin
      if (press_i) begin
         cnt_q <= hold_i;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule : mrs_pin_model

// [testbench/tb_mcu_reset_sequencer.sv]
module tb_mcu_reset_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   import mrs_pkg::*;
   localparam int PD = 20;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        uv = 1'b0;
   logic        slow = 1'b0;
   logic        wdt = 1'b0;
   logic        halt_i = 1'b0;
   logic        clrwdt_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [2:0]  hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h0;
   logic        press = 1'b0;
   logic [7:0]  hold = 8'h0;
   logic        rd_dph = 1'b0;
   logic        pin_n;
   logic [31:0] hrdata_o;
   logic        hreadyout_o, hresp_o, core_rst_n_o, pc_clr_o;
   logic        port_preset_o, run_o, init_pin_is_reset_o, irq_o;
   logic [31:0] exp_q[$];
   logic [31:0] r;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          rst_seen = 0;
   int          n;

   mrs_top #(.PU_DELAY_CYC(PD)) uut (
      .clk_i, .nrst_i,
      .external_init_pin_n_i  (pin_n),
      .undervoltage_monitor_i (uv),
      .slow_internal_osc_i    (slow),
      .wdt_ovf_i              (wdt),
      .halt_i, .clrwdt_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i                (hsize_i),
      .hwdata_i,
      .hready_i               (hreadyout_o),
      .hrdata_o, .hreadyout_o, .hresp_o, .core_rst_n_o, .pc_clr_o,
      .port_preset_o, .run_o, .init_pin_is_reset_o, .irq_o
   );

   mrs_pin_model partner (
      .clk_i   (clk_i),
      .press_i (press),
      .hold_i  (hold),
      .pin_n_o (pin_n)
   );

   always #5 clk_i = ~clk_i;

   always begin
      repeat (8) @(posedge clk_i);
      slow <= ~slow;
   end

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk

   task automatic complete_run();
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   // read data is taken at the edge that ends the data phase
   always @(posedge clk_i) begin
      if (rd_dph && hreadyout_o === 1'b1) begin
         chk(exp_q.pop_front(), hrdata_o);
         chk(32'h0, 32'(hresp_o));
      end
      if (core_rst_n_o === 1'b0)
         rst_seen++;
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   // ****************************************
   // bus master and waits
   // ****************************************
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= w;
      hsize_i <= 3'h2;
      htrans_i <= 2'h2;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      rd_dph <= !w;
      if (!w)
         exp_q.push_back(d);
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd_dph <= 1'b0;
   endtask : bus

   task automatic wait_run(output int k);
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (run_o !== 1'b1);
   endtask : wait_run

   initial begin
      void'($urandom(32'h5c1483b6));
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      chk(32'h6, {29'h0, pc_clr_o, port_preset_o, run_o});
      wait_run(n);
      chk(32'h1, 32'(n >= PD + 10 && n <= PD + 24));
      bus(1'b0, OFF_SEL, 32'h0);
      bus(1'b0, OFF_FLAGS, 32'h0);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'h0, 32'(core_rst_n_o));
      wait_run(n);
      bus(1'b0, OFF_FLAGS, 32'h1);
      halt_i <= 1'b1;
      @(posedge clk_i);
      halt_i <= 1'b0;
      bus(1'b0, OFF_FLAGS, 32'h7);
      rst_seen = 0;
      uv <= 1'b1;
      repeat (150) @(posedge clk_i);
      uv <= 1'b0;
      repeat (4) @(posedge clk_i);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
      wait_run(n);
      // run_o is launched on the edge ending the last start-up clock; wait_run sees it one edge later
      chk(32'(SST_CYC + 1), 32'(n));
      chk(32'h0, 32'(rst_seen));
      bus(1'b0, OFF_FLAGS, 32'h3);
      clrwdt_i <= 1'b1;
      @(posedge clk_i);
      clrwdt_i <= 1'b0;
      bus(1'b0, OFF_FLAGS, 32'h1);
      // a dip shorter than the qualification time
      uv <= 1'b1;
      repeat (40 + $urandom % 50) @(posedge clk_i);
      uv <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(32'h0, 32'(rst_seen));
      uv <= 1'b1;
      repeat (UV_MIN_CYC + 10) @(posedge clk_i);
      chk(32'h1, {30'h0, core_rst_n_o, port_preset_o});
      uv <= 1'b0;
      wait_run(n);
      bus(1'b1, OFF_SEL, 32'h35);
      bus(1'b0, OFF_SEL, 32'h15);
      chk(32'h1, 32'(init_pin_is_reset_o));
      hold <= 8'd20 + 8'($urandom % 30);
      press <= 1'b1;
      @(posedge clk_i);
      press <= 1'b0;
      repeat (8) @(posedge clk_i);
      r = {28'h0, core_rst_n_o, pc_clr_o, port_preset_o, run_o};
      chk(32'h6, r);
      while (pin_n !== 1'b1) @(posedge clk_i);
      wait_run(n);
      chk(32'h1, 32'(n >= PD + 16 && n <= PD + 24));
      bus(1'b0, OFF_FLAGS, 32'h1);
      bus(1'b0, OFF_SEL, 32'h0);
      // in plain I/O mode a press on the pin must not reset
      chk(32'h0, 32'(init_pin_is_reset_o));
      rst_seen = 0;
      press <= 1'b1;
      @(posedge clk_i);
      press <= 1'b0;
      repeat (hold + 8) @(posedge clk_i);
      chk(32'h0, 32'(rst_seen));
      bus(1'b1, OFF_SEL, 32'h07);
      n = 0;
      while (core_rst_n_o !== 1'b0) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'h1, 32'(n >= 30 && n <= 56));
      wait_run(n);
      // ****************************************
      // interrupt block
      // ****************************************
      bus(1'b0, OFF_IRQ_ST, 32'h1f);
      r = $urandom & 32'h1f;
      bus(1'b1, OFF_IRQ_EN, r);
      bus(1'b0, OFF_IRQ_EN, r);
      chk(32'(r != 32'h0), 32'(irq_o));
      bus(1'b1, OFF_IRQ_CLR, 32'h0f);
      bus(1'b0, OFF_IRQ_CLR, 32'h0);
      bus(1'b0, OFF_IRQ_ST, 32'h10);
      bus(1'b1, OFF_IRQ_EN, 32'h0f);
      repeat (2) @(posedge clk_i);
      chk(32'h0, 32'(irq_o));
      bus(1'b1, OFF_IRQ_EN, 32'h10);
      repeat (2) @(posedge clk_i);
      chk(32'h1, 32'(irq_o));
      bus(1'b1, OFF_IRQ_CLR, 32'h10);
      repeat (2) @(posedge clk_i);
      chk(32'h0, 32'(irq_o));
      bus(1'b0, 32'h40, 32'h0);
      // a second power-on reset taken from sleep clears both flags
      halt_i <= 1'b1;
      @(posedge clk_i);
      halt_i <= 1'b0;
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      wait_run(n);
      chk(32'h1, 32'(n >= PD + 16 && n <= PD + 24));
      bus(1'b0, OFF_FLAGS, 32'h0);
      bus(1'b0, OFF_IRQ_ST, 32'h0);
      complete_run();
   end
endmodule : tb_mcu_reset_sequencer
